// file: sdv_dev.sv
// Purpose: playback routing, mute, linked digital gain, soft-stepping
// Assumes: one sample period is one pair drained from the FIFO
// Notes: gain is mantissa times power of two, 6 dB taken per 12 codes
// Function
// - left power bit controls left channel
// - right power bit controls right channel
// - left select: off, left, right, mix
// - right select: off, right, left, mix
// - soft-step one or two periods per step
// - step mode 10 immediate; never 11
// - left mute bit, reset muted
// - right mute bit, reset muted
// - link copies other channel programmed gain
// - link 00 or 11 keeps gains independent
// - compressor on forces independent gains
// - left gain signed half-dB code, reset 0
// - right gain same coding, reset 0
// - host never writes reserved gain codes
// - host writes zeros to upper mute bits
// - compressor enable bits per channel, reset off
`timescale 1ns/100ps
module sdv_dev
  import sdv_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // link to host
  sdv_if.dev bus,
  // converter channels
  output logic dac_valid,
  input wire logic dac_ready,
  output logic [SDV_SMP_W-1:0] dac_left,
  output logic [SDV_SMP_W-1:0] dac_right,
  output logic dac_left_pwr,
  output logic dac_right_pwr,
  // compressor enables
  output logic drc_left_en,
  output logic drc_right_en
);
  typedef struct packed {
    logic [7:0] path;
    logic [7:0] mute;
    logic [7:0] gain_l;
    logic [7:0] gain_r;
    logic [7:0] dynamic_range_compressor;
    logic signed [7:0] cur_l;
    logic signed [7:0] cur_r;
    logic phase;
    logic rvalid;
    logic [7:0] rdata;
    logic out_valid;
    logic [SDV_SMP_W-1:0] out_l;
    logic [SDV_SMP_W-1:0] out_r;
  } sdv_dev_s;

  sdv_dev_s st;
  sdv_dev_s next_st;
  logic f_valid;
  logic f_ready;
  logic [SDV_FIFO_W-1:0] f_data;
  logic signed [SDV_SMP_W-1:0] in_l;
  logic signed [SDV_SMP_W-1:0] in_r;
  logic signed [SDV_SMP_W-1:0] mix;
  logic signed [SDV_SMP_W:0] sum;
  logic signed [7:0] tgt_l;
  logic signed [7:0] tgt_r;
  logic drc_any;
  sdv_link_e link;
  sdv_step_e step;
  logic pop;
  logic [7:0] rd_mux;

  // back-pressure from the converter reaches the host through this FIFO
  sdv_fifo #(
    .W(SDV_FIFO_W),
    .D(SDV_FIFO_D)
  ) u_fifo (
    .clk(clk),
    .rst_n(rst_n),
    .in_valid(bus.s_valid),
    .in_ready(bus.s_ready),
    .in_data({bus.s_left, bus.s_right}),
    .out_valid(f_valid),
    .out_ready(f_ready),
    .out_data(f_data)
  );

  function automatic logic signed [SDV_SMP_W-1:0] route(
    input logic [1:0] sel,
    input logic signed [SDV_SMP_W-1:0] own,
    input logic signed [SDV_SMP_W-1:0] oth,
    input logic signed [SDV_SMP_W-1:0] mx
  );
    logic signed [SDV_SMP_W-1:0] r;
    unique case (sdv_sel_e'(sel))
      SDV_SEL_OFF: r = '0;
      SDV_SEL_OWN: r = own;
      SDV_SEL_OTHER: r = oth;
      SDV_SEL_MIX: r = mx;
    endcase
    return r;
  endfunction

  // code g = 12*(q-11) + r; result = x * mant[r] * 2^(q-11) / 2^14
  function automatic logic signed [SDV_SMP_W-1:0] apply_gain(
    input logic signed [SDV_SMP_W-1:0] x,
    input logic signed [7:0] g
  );
    logic [8:0] u;
    logic [4:0] q;
    logic [3:0] r;
    logic [4:0] sh;
    logic signed [32:0] p;
    logic signed [32:0] s;
    logic signed [SDV_SMP_W-1:0] y;
    u = {g[7], g} + SDV_GAIN_BIAS;
    q = 5'(u / SDV_GAIN_DIV);
    r = 4'(u % SDV_GAIN_DIV);
    sh = SDV_SHIFT_BASE - q;
    p = 33'(x) * $signed({17'h00000, SDV_MANT[r]});
    s = p >>> sh;
    // positive codes can overflow 16 bits, so clip rather than wrap
    if (s > SDV_SAT_HI) begin
      y = 16'sh7fff;
    end else if (s < SDV_SAT_LO) begin
      y = 16'sh8000;
    end else begin
      y = 16'(s);
    end
    return y;
  endfunction

  function automatic logic signed [7:0] step_to(
    input logic signed [7:0] cur,
    input logic signed [7:0] tgt
  );
    logic signed [7:0] n;
    if (cur < tgt) begin
      n = cur + 8'sh01;
    end else if (cur > tgt) begin
      n = cur - 8'sh01;
    end else begin
      n = cur;
    end
    return n;
  endfunction

  assign in_l = f_data[SDV_FIFO_W-1 -: SDV_SMP_W];
  assign in_r = f_data[SDV_SMP_W-1:0];
  assign sum = 17'(in_l) + 17'(in_r);
  assign mix = 16'(sum >>> 1);
  assign link = sdv_link_e'(st.mute[SDV_LINK_LSB +: 2]);
  assign step = sdv_step_e'(st.path[SDV_STEP_LSB +: 2]);
  assign drc_any = st.dynamic_range_compressor[SDV_DRC_L_BIT] || st.dynamic_range_compressor[SDV_DRC_R_BIT];
  assign pop = f_valid && (!st.out_valid || dac_ready);
  assign f_ready = !st.out_valid || dac_ready;

  always_comb begin
    tgt_l = st.gain_l;
    tgt_r = st.gain_r;
    if (!drc_any) begin
      if (link == SDV_LINK_L_FROM_R) begin
        tgt_l = st.gain_r;
      end
      if (link == SDV_LINK_R_FROM_L) begin
        tgt_r = st.gain_l;
      end
    end
  end

  always_comb begin
    unique case (bus.reg_addr)
      SDV_ADDR_PATH: rd_mux = st.path;
      SDV_ADDR_MUTE: rd_mux = st.mute;
      SDV_ADDR_GAIN_L: rd_mux = st.gain_l;
      SDV_ADDR_GAIN_R: rd_mux = st.gain_r;
      SDV_ADDR_DRC: rd_mux = st.dynamic_range_compressor;
      default: rd_mux = 8'h00;
    endcase
  end

  always_comb begin
    next_st = st;
    next_st.rvalid = bus.reg_rd;
    if (bus.reg_rd) begin
      next_st.rdata = rd_mux;
    end
    if (bus.reg_wr) begin
      unique case (bus.reg_addr)
        SDV_ADDR_PATH: next_st.path = bus.reg_wdata;
        SDV_ADDR_MUTE: next_st.mute = bus.reg_wdata;
        SDV_ADDR_GAIN_L: next_st.gain_l = bus.reg_wdata;
        SDV_ADDR_GAIN_R: next_st.gain_r = bus.reg_wdata;
        SDV_ADDR_DRC: next_st.dynamic_range_compressor = bus.reg_wdata;
        default: ;
      endcase
    end
    if (dac_ready) begin
      next_st.out_valid = 1'b0;
    end
    if (pop) begin
      next_st.out_valid = 1'b1;
      next_st.out_l = '0;
      next_st.out_r = '0;
      // powered-down or muted channels send silence
      if (st.path[SDV_PWR_L_BIT] && !st.mute[SDV_MUTE_L_BIT]) begin
        next_st.out_l = apply_gain(
          route(st.path[SDV_SEL_L_LSB +: 2], in_l, in_r, mix),
          st.cur_l);
      end
      if (st.path[SDV_PWR_R_BIT] && !st.mute[SDV_MUTE_R_BIT]) begin
        next_st.out_r = apply_gain(
          route(st.path[SDV_SEL_R_LSB +: 2], in_r, in_l, mix),
          st.cur_r);
      end
    end
    // reserved step code treated like immediate, never left frozen
    if (step == SDV_STEP_NONE || step == SDV_STEP_RSVD) begin
      next_st.cur_l = tgt_l;
      next_st.cur_r = tgt_r;
      next_st.phase = 1'b0;
    end else if (pop) begin
      if (step == SDV_STEP_ONE || st.phase) begin
        next_st.cur_l = step_to(st.cur_l, tgt_l);
        next_st.cur_r = step_to(st.cur_r, tgt_r);
      end
      next_st.phase = (step == SDV_STEP_TWO) && !st.phase;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st <= '0;
      st.path <= SDV_RST_PATH;
      st.mute <= SDV_RST_MUTE;
      st.gain_l <= SDV_RST_GAIN;
      st.gain_r <= SDV_RST_GAIN;
      st.dynamic_range_compressor <= SDV_RST_DRC;
    end else begin
      st <= next_st;
    end
  end

  assign bus.reg_rdata = st.rdata;
  assign bus.reg_rvalid = st.rvalid;
  assign dac_valid = st.out_valid;
  assign dac_left = st.out_l;
  assign dac_right = st.out_r;
  assign dac_left_pwr = st.path[SDV_PWR_L_BIT];
  assign dac_right_pwr = st.path[SDV_PWR_R_BIT];
  assign drc_left_en = st.dynamic_range_compressor[SDV_DRC_L_BIT];
  assign drc_right_en = st.dynamic_range_compressor[SDV_DRC_R_BIT];
endmodule

// file: sdv_fifo.sv
// Purpose: sample FIFO with valid/ready on both sides
// Assumes: depth is a power of two
// Notes: storage array has no reset; only pointers are state
`timescale 1ns/100ps
module sdv_fifo
  import sdv_pkg::*;
#(
  parameter int W = SDV_FIFO_W,
  parameter int D = SDV_FIFO_D
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int AW = $clog2(D);

  typedef struct packed {
    logic [AW:0] wr;
    logic [AW:0] rd;
  } sdv_fifo_s;

  sdv_fifo_s st;
  sdv_fifo_s next_st;
  logic [W-1:0] mem [D];
  logic push;
  logic pop;

  // extra pointer bit tells full from empty
  assign out_valid = st.wr != st.rd;
  assign in_ready = st.wr != {~st.rd[AW], st.rd[AW-1:0]};
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem[st.rd[AW-1:0]];

  always_comb begin
    next_st = st;
    if (push) begin
      next_st.wr = st.wr + 1'b1;
    end
    if (pop) begin
      next_st.rd = st.rd + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  always_ff @(posedge clk) begin
    if (push) begin
      mem[st.wr[AW-1:0]] <= in_data;
    end
  end
endmodule

// file: sdv_host.sv
// Purpose: host end; register commands and sample stream onto the link
// Assumes: one command outstanding while a read is in flight
// Notes: writes are cleaned of reserved codes before they leave
`timescale 1ns/100ps
module sdv_host
  import sdv_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // link to device
  sdv_if.host bus,
  // register commands
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic cmd_write,
  input wire logic [7:0] cmd_addr,
  input wire logic [7:0] cmd_wdata,
  output logic rsp_valid,
  output logic [7:0] rsp_data,
  // samples
  input wire logic smp_valid,
  output logic smp_ready,
  input wire logic [SDV_SMP_W-1:0] smp_left,
  input wire logic [SDV_SMP_W-1:0] smp_right
);
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic rd_wait;
    logic fix;
    logic drc_on;
    logic [7:0] mute;
    logic rsp_valid;
    logic [7:0] rsp_data;
  } sdv_host_s;

  sdv_host_s st;
  sdv_host_s next_st;
  logic take;
  logic [7:0] clean;
  logic signed [7:0] g;

  assign cmd_ready = !st.rd_wait && !st.fix;
  assign take = cmd_valid && cmd_ready;
  assign g = cmd_wdata;

  always_comb begin
    clean = cmd_wdata;
    unique case (cmd_addr)
      SDV_ADDR_PATH: begin
        if (cmd_wdata[SDV_STEP_LSB +: 2] == SDV_STEP_RSVD) begin
          clean[SDV_STEP_LSB +: 2] = SDV_STEP_NONE;
        end
      end
      SDV_ADDR_MUTE: begin
        clean = cmd_wdata & ~SDV_MUTE_RSVD;
        if (st.drc_on) begin
          clean[SDV_LINK_LSB +: 2] = SDV_LINK_IND;
        end
      end
      SDV_ADDR_GAIN_L, SDV_ADDR_GAIN_R: begin
        if (g > SDV_GAIN_MAX) begin
          clean = SDV_GAIN_MAX;
        end else if (g == SDV_GAIN_FORBID) begin
          clean = SDV_GAIN_MIN;
        end
      end
      SDV_ADDR_DRC: clean = cmd_wdata & ~SDV_DRC_RSVD;
      default: ;
    endcase
  end

  always_comb begin
    next_st = st;
    next_st.wr = 1'b0;
    next_st.rd = 1'b0;
    next_st.rsp_valid = 1'b0;
    if (st.fix) begin
      // compressor just turned on with a link pending: clear the link
      next_st.fix = 1'b0;
      next_st.wr = 1'b1;
      next_st.addr = SDV_ADDR_MUTE;
      next_st.wdata = st.mute & ~8'h03;
      next_st.mute = st.mute & ~8'h03;
    end else if (take) begin
      next_st.addr = cmd_addr;
      next_st.wdata = clean;
      next_st.wr = cmd_write;
      next_st.rd = !cmd_write;
      next_st.rd_wait = !cmd_write;
      if (cmd_write && cmd_addr == SDV_ADDR_MUTE) begin
        next_st.mute = clean;
      end
      if (cmd_write && cmd_addr == SDV_ADDR_DRC) begin
        next_st.drc_on = clean[SDV_DRC_L_BIT] || clean[SDV_DRC_R_BIT];
        next_st.fix = (clean[SDV_DRC_L_BIT] || clean[SDV_DRC_R_BIT])
                      && (st.mute[SDV_LINK_LSB +: 2] != 2'h0);
      end
    end
    if (bus.reg_rvalid && st.rd_wait) begin
      next_st.rd_wait = 1'b0;
      next_st.rsp_valid = 1'b1;
      next_st.rsp_data = bus.reg_rdata;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st <= '0;
      st.mute <= SDV_RST_MUTE;
    end else begin
      st <= next_st;
    end
  end

  assign bus.reg_wr = st.wr;
  assign bus.reg_rd = st.rd;
  assign bus.reg_addr = st.addr;
  assign bus.reg_wdata = st.wdata;
  assign rsp_valid = st.rsp_valid;
  assign rsp_data = st.rsp_data;
  // samples pass straight to the device FIFO; its ready stalls the source
  assign bus.s_valid = smp_valid;
  assign bus.s_left = smp_left;
  assign bus.s_right = smp_right;
  assign smp_ready = bus.s_ready;
endmodule

// file: sdv_if.sv
// Purpose: link between host end and playback volume/routing end
// Assumes: single clock, both ends on clk
// Notes: register strobes are one-cycle pulses
`timescale 1ns/100ps
interface sdv_if (
  input wire logic clk
);
  import sdv_pkg::*;
  logic reg_wr;
  logic reg_rd;
  logic [7:0] reg_addr;
  logic [7:0] reg_wdata;
  logic [7:0] reg_rdata;
  logic reg_rvalid;
  logic s_valid;
  logic s_ready;
  logic [SDV_SMP_W-1:0] s_left;
  logic [SDV_SMP_W-1:0] s_right;

  modport dev (
    input reg_wr, reg_rd, reg_addr, reg_wdata, s_valid, s_left, s_right,
    output reg_rdata, reg_rvalid, s_ready
  );
  modport host (
    output reg_wr, reg_rd, reg_addr, reg_wdata, s_valid, s_left, s_right,
    input reg_rdata, reg_rvalid, s_ready
  );
endinterface

// file: sdv_pkg.sv
// Purpose: shared constants and types of the playback volume/routing path
// Assumes: 8-bit register port, 16-bit stereo samples
// Notes: gain mantissas are Q14 values of 10^(r/40), r = 0..11
package sdv_pkg;
  // register offsets
  localparam logic [7:0] SDV_ADDR_PATH = 8'h3f;
  localparam logic [7:0] SDV_ADDR_MUTE = 8'h40;
  localparam logic [7:0] SDV_ADDR_GAIN_L = 8'h41;
  localparam logic [7:0] SDV_ADDR_GAIN_R = 8'h42;
  localparam logic [7:0] SDV_ADDR_DRC = 8'h44;
  // values after reset
  localparam logic [7:0] SDV_RST_PATH = 8'h14;
  localparam logic [7:0] SDV_RST_MUTE = 8'h0c;
  localparam logic [7:0] SDV_RST_GAIN = 8'h00;
  localparam logic [7:0] SDV_RST_DRC = 8'h0f;
  // field positions
  localparam int SDV_PWR_L_BIT = 7;
  localparam int SDV_PWR_R_BIT = 6;
  localparam int SDV_SEL_L_LSB = 4;
  localparam int SDV_SEL_R_LSB = 2;
  localparam int SDV_STEP_LSB = 0;
  localparam int SDV_MUTE_L_BIT = 3;
  localparam int SDV_MUTE_R_BIT = 2;
  localparam int SDV_LINK_LSB = 0;
  localparam int SDV_DRC_L_BIT = 6;
  localparam int SDV_DRC_R_BIT = 5;
  localparam logic [7:0] SDV_MUTE_RSVD = 8'hf0;
  localparam logic [7:0] SDV_DRC_RSVD = 8'h80;

  typedef enum logic [1:0] {
    SDV_SEL_OFF = 2'h0, SDV_SEL_OWN = 2'h1,
    SDV_SEL_OTHER = 2'h2, SDV_SEL_MIX = 2'h3
  } sdv_sel_e;
  typedef enum logic [1:0] {
    SDV_STEP_ONE = 2'h0, SDV_STEP_TWO = 2'h1,
    SDV_STEP_NONE = 2'h2, SDV_STEP_RSVD = 2'h3
  } sdv_step_e;
  typedef enum logic [1:0] {
    SDV_LINK_IND = 2'h0, SDV_LINK_L_FROM_R = 2'h1,
    SDV_LINK_R_FROM_L = 2'h2, SDV_LINK_IND2 = 2'h3
  } sdv_link_e;

  // gain coding
  localparam logic signed [7:0] SDV_GAIN_MAX = 8'sh30;
  localparam logic signed [7:0] SDV_GAIN_MIN = 8'sh81;
  localparam logic signed [7:0] SDV_GAIN_FORBID = 8'sh80;
  localparam logic [8:0] SDV_GAIN_BIAS = 9'h084;
  localparam logic [8:0] SDV_GAIN_DIV = 9'h00c;
  localparam logic [4:0] SDV_SHIFT_BASE = 5'h19;
  localparam logic [15:0] SDV_MANT [12] = '{
    16'h4000, 16'h43cb, 16'h47cf, 16'h4c10, 16'h5092, 16'h5558,
    16'h5a67, 16'h5fc2, 16'h656f, 16'h6b72, 16'h71d0, 16'h788e};
  localparam logic signed [32:0] SDV_SAT_HI = 33'sh0_0000_7fff;
  localparam logic signed [32:0] SDV_SAT_LO = 33'sh1_ffff_8000;

  // widths and depths
  localparam int SDV_SMP_W = 16;
  localparam int SDV_FIFO_W = 32;
  localparam int SDV_FIFO_D = 32;
endpackage

// file: sdv_properties.sv
// Purpose: link checks between the host end and the playback end
// Assumes: one clock, synchronous active-low reset
// Notes: a shadow copy mirrors every write seen on the link
`timescale 1ns/100ps
module sdv_properties
  import sdv_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // register link
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rvalid
);
  logic [7:0] sh [5];
  logic [7:0] exp_rd;
  logic drc_on;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sh <= '{SDV_RST_PATH, SDV_RST_MUTE, SDV_RST_GAIN, SDV_RST_GAIN,
        SDV_RST_DRC};
    end else if (reg_wr) begin
      case (reg_addr)
        SDV_ADDR_PATH: sh[0] <= reg_wdata;
        SDV_ADDR_MUTE: sh[1] <= reg_wdata;
        SDV_ADDR_GAIN_L: sh[2] <= reg_wdata;
        SDV_ADDR_GAIN_R: sh[3] <= reg_wdata;
        SDV_ADDR_DRC: sh[4] <= reg_wdata;
        default: ;
      endcase
    end
  end

  // unmapped places read as zero
  always_comb begin
    case (reg_addr)
      SDV_ADDR_PATH: exp_rd = sh[0];
      SDV_ADDR_MUTE: exp_rd = sh[1];
      SDV_ADDR_GAIN_L: exp_rd = sh[2];
      SDV_ADDR_GAIN_R: exp_rd = sh[3];
      SDV_ADDR_DRC: exp_rd = sh[4];
      default: exp_rd = 8'h00;
    endcase
  end
  assign drc_on = sh[4][6] | sh[4][5];

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence rd_issue;
    reg_rd;
  endsequence
  sequence rd_answer;
    reg_rvalid && reg_rdata == $past(exp_rd);
  endsequence
  sequence drc_turn_on;
    reg_wr && reg_addr == SDV_ADDR_DRC && (reg_wdata[6] | reg_wdata[5])
      && sh[1][1:0] != 2'h0;
  endsequence
  sequence link_cleared;
    reg_wr && reg_addr == SDV_ADDR_MUTE && reg_wdata[1:0] == 2'h0;
  endsequence

  chk_read_answer: assert property (rd_issue |=> rd_answer)
    else $error("read answer wrong or late");
  chk_rvalid_cause: assert property (reg_rvalid |-> $past(reg_rd))
    else $error("read answer without a read");
  chk_strobes_apart: assert property (!(reg_wr && reg_rd))
    else $error("read and write strobes together");
  chk_read_quiet: assert property (rd_issue |=> (!reg_rd && !reg_wr) [*2])
    else $error("new strobe while a read is pending");
  chk_step_legal: assert property (reg_wr && reg_addr == SDV_ADDR_PATH
    |-> reg_wdata[1:0] != 2'h3)
    else $error("reserved step mode written");
  chk_mute_upper: assert property (reg_wr && reg_addr == SDV_ADDR_MUTE
    |-> reg_wdata[7:4] == 4'h0)
    else $error("upper mute bits written nonzero");
  chk_gain_range: assert property (reg_wr && (reg_addr == SDV_ADDR_GAIN_L
    || reg_addr == SDV_ADDR_GAIN_R) |-> $signed(reg_wdata) <= SDV_GAIN_MAX
    && reg_wdata != SDV_GAIN_FORBID)
    else $error("reserved gain code written");
  chk_link_drc: assert property (reg_wr && reg_addr == SDV_ADDR_MUTE
    && drc_on |-> reg_wdata[1:0] == 2'h0)
    else $error("link set while compressor on");
  chk_link_fix: assert property (drc_turn_on |-> ##[1:2] link_cleared)
    else $error("link not cleared after compressor enable");
endmodule

// file: tb_stereo_dac_volume_routing.sv
// Purpose: end-to-end bench of the host and playback ends
// Assumes: settings change only while the stream is drained
// Notes: output pairs are predicted in push order
`timescale 1ns/100ps
module tb_stereo_dac_volume_routing
  import sdv_pkg::*;
;
  logic clk = 0, rst_n = 0, hold = 1, dac_ready = 0;
  logic cmd_valid = 0, cmd_write = 0, smp_valid = 0;
  logic [7:0] cmd_addr = 0, cmd_wdata = 0, rsp_data;
  logic cmd_ready, rsp_valid, smp_ready, dac_valid;
  logic [3:0] pins;
  logic [15:0] smp_left = 0, smp_right = 0, dac_left, dac_right;
  logic [31:0] seed = 32'hc23a17ff, seed_r = 32'hc23a17ff, e;
  logic [31:0] expq [$];
  logic [7:0] m [6] = '{SDV_RST_PATH, SDV_RST_MUTE, SDV_RST_GAIN,
    SDV_RST_GAIN, SDV_RST_DRC, 8'h00};
  logic [7:0] adr [5] = '{SDV_ADDR_PATH, SDV_ADDR_MUTE, SDV_ADDR_GAIN_L,
    SDV_ADDR_GAIN_R, SDV_ADDR_DRC};
  logic [7:0] cfg [5][5] = '{
    '{8'hc2, 8'h00, 8'h0a, 8'hec, 8'h0f},
    '{8'hec, 8'h01, 8'h30, 8'h81, 8'h0f},
    '{8'hf9, 8'h02, 8'h14, 8'h00, 8'h0f},
    '{8'hf7, 8'hf7, 8'h7f, 8'h80, 8'h0f},
    '{8'h94, 8'h01, 8'h05, 8'hfb, 8'hcf}};
  int miscompares = 0, checked = 0, al = 0, ar = 0, ph = 0, k;

  sdv_if u_sdv_if (.clk(clk));
  sdv_host u_sdv_host (.clk(clk), .rst_n(rst_n), .bus(u_sdv_if.host),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_write(cmd_write),
    .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .rsp_valid(rsp_valid),
    .rsp_data(rsp_data), .smp_valid(smp_valid), .smp_ready(smp_ready),
    .smp_left(smp_left), .smp_right(smp_right));
  sdv_dev u_sdv_dev (.clk(clk), .rst_n(rst_n), .bus(u_sdv_if.dev),
    .dac_valid(dac_valid), .dac_ready(dac_ready), .dac_left(dac_left),
    .dac_right(dac_right), .dac_left_pwr(pins[3]),
    .dac_right_pwr(pins[2]), .drc_left_en(pins[1]),
    .drc_right_en(pins[0]));
  sdv_properties u_sdv_properties (.clk(clk), .rst_n(rst_n),
    .reg_wr(u_sdv_if.reg_wr), .reg_rd(u_sdv_if.reg_rd),
    .reg_addr(u_sdv_if.reg_addr), .reg_wdata(u_sdv_if.reg_wdata),
    .reg_rdata(u_sdv_if.reg_rdata), .reg_rvalid(u_sdv_if.reg_rvalid));

  function automatic logic [31:0] nx(logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic int ix(logic [7:0] a);
    case (a)
      SDV_ADDR_PATH: return 0;
      SDV_ADDR_MUTE: return 1;
      SDV_ADDR_GAIN_L: return 2;
      SDV_ADDR_GAIN_R: return 3;
      SDV_ADDR_DRC: return 4;
      default: return 5;
    endcase
  endfunction
  function automatic int src(logic [1:0] s, logic signed [15:0] a,
    logic signed [15:0] b);
    case (s)
      2'h0: return 0;
      2'h1: return a;
      2'h2: return b;
      default: return (int'(a) + int'(b)) >>> 1;
    endcase
  endfunction
  // half-dB code to mantissa and shift, saturated to 16 bits
  function automatic logic [15:0] scale(int x, int g);
    longint p;
    int u;
    u = g + 132;
    p = (longint'(x) * longint'(SDV_MANT[u % 12])) >>> (25 - u / 12);
    if (p > 32767) p = 32767;
    if (p < -32768) p = -32768;
    return p[15:0];
  endfunction

  task automatic tally(string n, logic [31:0] x, logic [31:0] s);
    checked++;
    if (s !== x) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", n, x, s);
    end
  endtask
  task automatic cmp_reg(string n, logic [7:0] x, logic [7:0] s);
    tally(n, {24'h0, x}, {24'h0, s});
  endtask
  task automatic cmp_pin(string n, logic [3:0] x, logic [3:0] s);
    tally(n, {28'h0, x}, {28'h0, s});
  endtask
  task automatic cmp_smp(string n, logic [31:0] x, logic [31:0] s);
    tally(n, x, s);
  endtask
  task automatic conclude;
    if (miscompares == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic op(logic w, logic [7:0] a, logic [7:0] d);
    int n;
    @(posedge clk);
    #1;
    cmd_valid = 1;
    cmd_write = w;
    cmd_addr = a;
    cmd_wdata = d;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (cmd_ready !== 1'b1 && n < 20);
    // a command that is never taken counts against the run
    cmp_reg("cmd ready", 8'h01, {7'h0, cmd_ready});
    @(posedge clk);
    #1;
    cmd_valid = 0;
    if (!w) begin
      n = 0;
      do begin
        @(negedge clk);
        n++;
      end while (rsp_valid !== 1'b1 && n < 8);
      cmp_reg("rsp valid", 8'h01, {7'h0, rsp_valid});
      cmp_reg("readback", m[ix(a)], rsp_data);
    end
  endtask
  // the host cleans reserved values, so the model stores the cleaned form
  task automatic wr(logic [7:0] a, logic [7:0] d);
    logic [7:0] c;
    c = d;
    case (ix(a))
      0: if (c[1:0] == 2'h3) c[1:0] = 2'h2;
      1: begin
        c[7:4] = 4'h0;
        if (m[4][6] | m[4][5]) c[1:0] = 2'h0;
      end
      2, 3: begin
        if ($signed(c) > 48) c = 8'h30;
        if (c == 8'h80) c = 8'h81;
      end
      4: begin
        c[7] = 1'b0;
        if ((c[6] | c[5]) && m[1][1:0] != 2'h0) m[1][1:0] = 2'h0;
      end
      default: ;
    endcase
    m[ix(a)] = c;
    op(1'b1, a, d);
  endtask
  task automatic rd_all;
    for (int a = 'h3f; a < 'h45; a++) op(1'b0, a[7:0], 8'h00);
    cmp_pin("pins", {m[0][7:6], m[4][6:5]}, pins);
  endtask

  task automatic model(logic [15:0] l, logic [15:0] r);
    int tl, tr;
    logic dynamic_range_compressor;
    logic [15:0] ol, orr;
    dynamic_range_compressor = m[4][6] | m[4][5];
    tl = $signed(m[2]);
    tr = $signed(m[3]);
    if (!dynamic_range_compressor && m[1][1:0] == 2'h1) tl = tr;
    if (!dynamic_range_compressor && m[1][1:0] == 2'h2) tr = $signed(m[2]);
    if (m[0][1]) begin
      al = tl;
      ar = tr;
    end
    ol = 16'h0;
    orr = 16'h0;
    if (m[0][7] && !m[1][3]) ol = scale(src(m[0][5:4], l, r), al);
    if (m[0][6] && !m[1][2]) orr = scale(src(m[0][3:2], r, l), ar);
    expq.push_back({ol, orr});
    if (m[0][1:0] == 2'h0 || (m[0][1:0] == 2'h1 && ph != 0)) begin
      al = al + int'(tl > al) - int'(tl < al);
      ar = ar + int'(tr > ar) - int'(tr < ar);
    end
    ph = (m[0][1:0] == 2'h1) ? int'(ph == 0) : 0;
  endtask
  task automatic burst(int n);
    logic ok;
    k = 0;
    @(posedge clk);
    #1;
    seed = nx(seed);
    {smp_left, smp_right} = seed;
    smp_valid = 1;
    while (k < n) begin
      @(negedge clk);
      ok = smp_ready === 1'b1;
      if (ok) model(smp_left, smp_right);
      @(posedge clk);
      #1;
      if (ok) begin
        k++;
        seed = nx(seed);
        {smp_left, smp_right} = seed;
      end else if (hold) break;
    end
    smp_valid = 0;
  endtask
  task automatic drain;
    for (int n = 0; n < 800 && expq.size() > 0; n++) @(posedge clk);
    repeat (2) @(posedge clk);
  endtask

  initial forever #20 clk = ~clk;
  // far side stalls at random unless held off
  always @(posedge clk) begin
    #1;
    seed_r = nx(seed_r);
    dac_ready = !hold && (seed_r[2] || seed_r[5]);
  end
  always @(negedge clk) begin
    if (rst_n && dac_valid === 1'b1 && dac_ready === 1'b1) begin
      e = expq.size() > 0 ? expq.pop_front() : 'x;
      cmp_smp("dac pair", e, {dac_left, dac_right});
    end
  end
  // whole run is under a thousand cycles
  initial begin
    repeat (5000) @(posedge clk);
    miscompares++;
    conclude();
  end

  initial begin
    repeat (2) @(posedge clk);
    #1;
    rst_n = 1;
    rd_all();
    burst(40);
    cmp_reg("accepted", 8'd33, k[7:0]);
    @(negedge clk);
    hold = 0;
    drain();
    foreach (cfg[i]) begin
      for (int j = 0; j < 5; j++) wr(adr[j], cfg[i][j]);
      rd_all();
      burst(12);
      drain();
    end
    // a stalled output path would otherwise leave pairs unchecked
    cmp_reg("pending", 8'h00, 8'(expq.size()));
    conclude();
  end
endmodule
